// *** rtl/pst_fifo.sv ***
`timescale 1ns/1ps

module pst_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             push;
	logic             pop;
	logic             full;
	logic             empty;

	assign empty = (wr_ptr_reg == rd_ptr_reg);
	assign full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
	               (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign in_ready_out  = ~full;
	assign out_valid_out = ~empty;
	assign push = in_valid_in & ~full;
	assign pop  = out_ready_in & ~empty;
	assign out_data_out = mem[rd_ptr_reg[AW-1:0]];

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem[wr_ptr_reg[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_ptr_reg <= '0;
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule

// *** rtl/pst_i2c_target.sv ***
`timescale 1ns/1ps
`include "pst_params.svh"

// Summary of operation
// - Only answers transfers a master begins; never starts one itself.
// - On read, sends status byte then three pressure bytes.
// - Selected by a 7-bit address, default hex 18.
// - Address selectable among 08, 28, 38, 48, 58, 68, 78 instead.
// - Sensor acks its address; master acks each byte it still wants.
// - Master NACK then STOP ends a read; sensor releases data line.
// - Status bits 7, 4, 3 and 1 always zero.
// - Status bit 6 is one whenever powered and out of reset.
// - Status bit 5 is one while the last command's result is pending.
// - A command arriving while busy is ignored.
// - Status bit 2 holds memory check failure, sampled once after each reset release.
// - Status bit 0 set when compensation math saturated.
// - Command wakes sensor, runs one measurement, returns to standby.
// - Works at 100 kbit/s and 400 kbit/s bus rates.
// - Lines only pulled low or released, never driven high.
module pst_i2c_target (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_out,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	input  wire logic [2:0]  addr_sel_in,
	input  wire logic        mem_fail_in,
	output logic             meas_start_out,
	output logic             operating_out,
	input  wire logic [23:0] meas_data_in,
	input  wire logic        meas_sat_in,
	input  wire logic        meas_valid_in,
	output logic             meas_ready_out,
	output logic [7:0]       status_out
);

	pst_pkg::pst_state_e state_reg;
	pst_pkg::pst_byte_t  shift_reg;
	pst_pkg::pst_byte_t  rx_data_reg;
	pst_pkg::pst_byte_t  tx_byte;
	pst_pkg::pst_byte_t  status_reg;
	pst_pkg::pst_byte_t  status_next;

	logic [1:0]  scl_sync_reg;
	logic [1:0]  sda_sync_reg;
	logic        scl_prev_reg;
	logic        sda_prev_reg;
	logic [2:0]  sel_sync1_reg;
	logic [2:0]  sel_sync2_reg;
	logic        scl_s;
	logic        sda_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;

	logic [6:0]  addr_reg;
	logic [6:0]  addr_next;
	logic [3:0]  bit_cnt_reg;
	logic        rw_reg;
	logic        sda_oe_reg;
	logic [1:0]  rx_idx_reg;
	logic [1:0]  rx_pos_reg;
	logic        rx_done_reg;
	logic [2:0]  tx_idx_reg;
	logic        tx_active;

	logic        cmd_ok_reg;
	logic        busy_reg;
	logic        start_reg;
	logic        power_reg;
	logic        mem_done_reg;
	logic        mem_err_reg;
	logic [23:0] result_reg;
	logic        sat_reg;

	logic                        res_valid;
	logic                        res_pop;
	logic [`PST_FIFO_WIDTH-1:0]  res_data;

	// Bus pins are asynchronous: two flops, then a third for edges
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_prev_reg <= scl_sync_reg[1];
			sda_prev_reg <= sda_sync_reg[1];
		end
	end

	// Sampling at 125 MHz leaves hundreds of samples per bit at 400 kHz
	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s & ~scl_prev_reg;
	assign scl_fall  = ~scl_s & scl_prev_reg;
	assign start_det = scl_s & scl_prev_reg & ~sda_s & sda_prev_reg;
	assign stop_det  = scl_s & scl_prev_reg & sda_s & ~sda_prev_reg;

	// Address strap pins, synchronised like the bus lines
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sel_sync1_reg <= 3'h0;
			sel_sync2_reg <= 3'h0;
		end else begin
			sel_sync1_reg <= addr_sel_in;
			sel_sync2_reg <= sel_sync1_reg;
		end
	end

	always_comb begin
		case (sel_sync2_reg)
			3'h1:    addr_next = `PST_ADDR_ALT1;
			3'h2:    addr_next = `PST_ADDR_ALT2;
			3'h3:    addr_next = `PST_ADDR_ALT3;
			3'h4:    addr_next = `PST_ADDR_ALT4;
			3'h5:    addr_next = `PST_ADDR_ALT5;
			3'h6:    addr_next = `PST_ADDR_ALT6;
			3'h7:    addr_next = `PST_ADDR_ALT7;
			default: addr_next = `PST_ADDR_DEFAULT;
		endcase
	end

	// Address only changes between transfers
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			addr_reg <= `PST_ADDR_DEFAULT;
		end else if (state_reg == pst_pkg::PST_IDLE) begin
			addr_reg <= addr_next;
		end
	end

	// Byte presented on a read: status, then pressure high to low
	always_comb begin
		case (tx_idx_reg)
			`PST_TX_FIRST: tx_byte = status_reg;
			`PST_TX_P_HI:  tx_byte = result_reg[23:16];
			`PST_TX_P_MID: tx_byte = result_reg[15:8];
			`PST_TX_P_LO:  tx_byte = result_reg[7:0];
			default:       tx_byte = `PST_TX_FILL;
		endcase
	end

	// Bus protocol engine; it only reacts to master-made conditions
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			state_reg   <= pst_pkg::PST_IDLE;
			shift_reg   <= `PST_ST_ZERO;
			bit_cnt_reg <= `PST_BIT_NONE;
			rw_reg      <= 1'b0;
			sda_oe_reg  <= 1'b0;
			rx_idx_reg  <= 2'h0;
			rx_pos_reg  <= 2'h0;
			rx_done_reg <= 1'b0;
			rx_data_reg <= `PST_ST_ZERO;
			tx_idx_reg  <= `PST_TX_FIRST;
		end else begin
			rx_done_reg <= 1'b0;
			if (start_det) begin
				state_reg   <= pst_pkg::PST_ADDR;
				bit_cnt_reg <= `PST_BIT_NONE;
				sda_oe_reg  <= 1'b0;
				rx_idx_reg  <= 2'h0;
				tx_idx_reg  <= `PST_TX_FIRST;
			end else if (stop_det) begin
				state_reg  <= pst_pkg::PST_IDLE;
				sda_oe_reg <= 1'b0;
			end else begin
				case (state_reg)
					pst_pkg::PST_ADDR, pst_pkg::PST_RX: begin
						if (scl_rise) begin
							shift_reg   <= {shift_reg[6:0], sda_s};
							bit_cnt_reg <= bit_cnt_reg + `PST_BIT_ONE;
						end else if (scl_fall &&
						             bit_cnt_reg == `PST_BIT_LAST) begin
							bit_cnt_reg <= `PST_BIT_NONE;
							if (state_reg == pst_pkg::PST_RX) begin
								sda_oe_reg  <= 1'b1;
								rx_done_reg <= 1'b1;
								rx_data_reg <= shift_reg;
								rx_pos_reg  <= rx_idx_reg;
								if (rx_idx_reg != `PST_RX_MAX) begin
									rx_idx_reg <= rx_idx_reg + 2'h1;
								end
								state_reg <= pst_pkg::PST_RX_ACK;
							end else if (shift_reg[7:1] == addr_reg) begin
								sda_oe_reg <= 1'b1;
								rw_reg     <= shift_reg[0];
								state_reg  <= pst_pkg::PST_ADDR_ACK;
							end else begin
								state_reg <= pst_pkg::PST_WAIT;
							end
						end
					end
					pst_pkg::PST_RX_ACK: begin
						if (scl_fall) begin
							sda_oe_reg <= 1'b0;
							state_reg  <= pst_pkg::PST_RX;
						end
					end
					pst_pkg::PST_ADDR_ACK, pst_pkg::PST_TX_ACK: begin
						if (scl_rise && state_reg == pst_pkg::PST_TX_ACK &&
						    sda_s) begin
							state_reg <= pst_pkg::PST_WAIT;
						end else if (scl_fall) begin
							if (state_reg == pst_pkg::PST_ADDR_ACK &&
							    !rw_reg) begin
								sda_oe_reg  <= 1'b0;
								bit_cnt_reg <= `PST_BIT_NONE;
								state_reg   <= pst_pkg::PST_RX;
							end else begin
								// Open drain: pull low only for a zero
								sda_oe_reg  <= ~tx_byte[7];
								shift_reg   <= {tx_byte[6:0], 1'b0};
								bit_cnt_reg <= `PST_BIT_ONE;
								if (tx_idx_reg != `PST_TX_MAX) begin
									tx_idx_reg <= tx_idx_reg + 3'h1;
								end
								state_reg <= pst_pkg::PST_TX;
							end
						end
					end
					pst_pkg::PST_TX: begin
						if (scl_fall) begin
							if (bit_cnt_reg == `PST_BIT_LAST) begin
								sda_oe_reg <= 1'b0;
								state_reg  <= pst_pkg::PST_TX_ACK;
							end else begin
								sda_oe_reg  <= ~shift_reg[7];
								shift_reg   <= {shift_reg[6:0], 1'b0};
								bit_cnt_reg <= bit_cnt_reg + `PST_BIT_ONE;
							end
						end
					end
					pst_pkg::PST_IDLE, pst_pkg::PST_WAIT: begin
						sda_oe_reg <= 1'b0;
					end
					default: begin
						state_reg  <= pst_pkg::PST_IDLE;
						sda_oe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// Command decoder: AA 00 00 starts one measurement when idle
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cmd_ok_reg <= 1'b0;
			start_reg  <= 1'b0;
		end else begin
			start_reg <= 1'b0;
			if (rx_done_reg) begin
				if (rx_pos_reg == 2'h0) begin
					cmd_ok_reg <= (rx_data_reg == `PST_CMD_MEASURE);
				end else if (rx_pos_reg == `PST_RX_MAX) begin
					cmd_ok_reg <= 1'b0;
				end else begin
					cmd_ok_reg <= cmd_ok_reg &&
					              (rx_data_reg == `PST_CMD_ARG);
					if (rx_pos_reg == `PST_RX_LAST && cmd_ok_reg &&
					    rx_data_reg == `PST_CMD_ARG && !busy_reg) begin
						start_reg <= 1'b1;
					end
				end
			end
		end
	end

	// Busy from command until its result leaves the FIFO; set wins
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			busy_reg <= 1'b0;
		end else if (start_reg) begin
			busy_reg <= 1'b1;
		end else if (res_pop) begin
			busy_reg <= 1'b0;
		end
	end

	// Result is frozen while a read is shifting it out
	assign tx_active = (state_reg == pst_pkg::PST_TX) ||
	                   (state_reg == pst_pkg::PST_TX_ACK);
	assign res_pop   = res_valid & ~tx_active;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			result_reg <= `PST_RESULT_ZERO;
			sat_reg    <= 1'b0;
		end else if (res_pop) begin
			result_reg <= res_data[23:0];
			sat_reg    <= res_data[24];
		end
	end

	pst_fifo #(
		.WIDTH (`PST_FIFO_WIDTH),
		.DEPTH (`PST_FIFO_DEPTH)
	) u_result_fifo (
		.ref_clk_in    (ref_clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (meas_valid_in),
		.in_ready_out  (meas_ready_out),
		.in_data_in    ({meas_sat_in, meas_data_in}),
		.out_valid_out (res_valid),
		.out_ready_in  (~tx_active),
		.out_data_out  (res_data)
	);

	// Power flag and one-shot memory check after reset release
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			power_reg    <= 1'b0;
			mem_done_reg <= 1'b0;
			mem_err_reg  <= 1'b0;
		end else begin
			power_reg <= 1'b1;
			if (!mem_done_reg) begin
				mem_err_reg  <= mem_fail_in;
				mem_done_reg <= 1'b1;
			end
		end
	end

	always_comb begin
		status_next = `PST_ST_ZERO;
		status_next[`PST_ST_POWER]  = power_reg;
		status_next[`PST_ST_BUSY]   = busy_reg;
		status_next[`PST_ST_MEMERR] = mem_err_reg;
		status_next[`PST_ST_SAT]    = sat_reg;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			status_reg <= `PST_ST_ZERO;
		end else begin
			status_reg <= status_next;
		end
	end

	assign status_out     = status_reg;
	assign meas_start_out = start_reg;
	assign operating_out  = busy_reg;
	assign sda_out        = 1'b0;
	assign sda_oe_out     = sda_oe_reg;
	assign scl_out        = 1'b0;
	assign scl_oe_out     = 1'b0;

endmodule

// *** rtl/pst_params.svh ***
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH

// Selectable 7-bit target addresses, index 0 is the default
`define PST_ADDR_DEFAULT 7'h18
`define PST_ADDR_ALT1    7'h08
`define PST_ADDR_ALT2    7'h28
`define PST_ADDR_ALT3    7'h38
`define PST_ADDR_ALT4    7'h48
`define PST_ADDR_ALT5    7'h58
`define PST_ADDR_ALT6    7'h68
`define PST_ADDR_ALT7    7'h78

// Measurement command sequence
`define PST_CMD_MEASURE  8'hAA
`define PST_CMD_ARG      8'h00

// Status byte field positions
`define PST_ST_POWER     6
`define PST_ST_BUSY      5
`define PST_ST_MEMERR    2
`define PST_ST_SAT       0
`define PST_ST_ZERO      8'h00

// Bit and byte counting
`define PST_BIT_NONE     4'h0
`define PST_BIT_ONE      4'h1
`define PST_BIT_LAST     4'h8
`define PST_RX_LAST      2'h2
`define PST_RX_MAX       2'h3
`define PST_TX_FIRST     3'h0
`define PST_TX_P_HI      3'h1
`define PST_TX_P_MID     3'h2
`define PST_TX_P_LO      3'h3
`define PST_TX_MAX       3'h4
`define PST_TX_FILL      8'hFF
`define PST_RESULT_ZERO  24'h000000

// Result FIFO shape: 24-bit pressure plus saturation flag
`define PST_FIFO_WIDTH   25
`define PST_FIFO_DEPTH   32

`endif

// *** rtl/pst_pkg.sv ***
package pst_pkg;

	typedef enum logic [2:0] {
		PST_IDLE,
		PST_ADDR,
		PST_ADDR_ACK,
		PST_RX,
		PST_RX_ACK,
		PST_TX,
		PST_TX_ACK,
		PST_WAIT
	} pst_state_e;

	typedef logic [7:0] pst_byte_t;

endpackage

// *** verification/pst_i2c_master.sv ***
`timescale 1ns/1ps

module pst_i2c_master (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_oe_out,
	output logic      sda_oe_out
);
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// Steps sit 3 ns past the system clock so the link has its own phase
	task automatic wt(input int n);
		repeat (n) @(posedge clk_in);
		#3;
	endtask

	// One SCL period of 160 ns, data set mid-low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		sda_oe_out = !b;
		wt(5);
		scl_oe_out = 1'b0;
		wt(5);
		r = sda_in;
		wt(5);
		scl_oe_out = 1'b1;
		wt(5);
	endtask

	task automatic start();
		sda_oe_out = 1'b0;
		wt(5);
		scl_oe_out = 1'b0;
		wt(10);
		sda_oe_out = 1'b1;
		wt(10);
		scl_oe_out = 1'b1;
		wt(5);
	endtask

	task automatic stop();
		sda_oe_out = 1'b1;
		wt(5);
		scl_oe_out = 1'b0;
		wt(10);
		sda_oe_out = 1'b0;
		wt(20);
	endtask

	task automatic xfer(input logic [7:0] d, input logic last,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(last, a);
	endtask
endmodule

// *** verification/pst_i2c_target_props.sv ***
`timescale 1ns/1ps

module pst_i2c_target_props (
	input wire logic       ref_clk_in,
	input wire logic       rst_in,
	input wire logic       scl_in,
	input wire logic       scl_oe_out,
	input wire logic       sda_out,
	input wire logic       sda_oe_out,
	input wire logic       mem_fail_in,
	input wire logic       meas_start_out,
	input wire logic       operating_out,
	input wire logic [7:0] status_out
);
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	chk_scl_released: assert property (!scl_oe_out)
		else $error("scl driven");
	chk_sda_pull_only: assert property (sda_oe_out |-> !sda_out)
		else $error("sda driven high");
	chk_zero_bits: assert property ((status_out & 8'h9A) == 8'h00)
		else $error("fixed status bits set");
	chk_power_bit: assert property (
		$fell(rst_in) |-> ##2 status_out[6] [*8])
		else $error("power bit missing");
	chk_busy_set: assert property (
		meas_start_out |-> ##[1:2] (operating_out && status_out[5]))
		else $error("busy not raised");
	chk_start_pulse: assert property (
		meas_start_out |=> !meas_start_out)
		else $error("start longer than one cycle");
	chk_idle_start: assert property (
		meas_start_out |-> !$past(operating_out))
		else $error("start while busy");
	chk_mem_load: assert property (
		$fell(rst_in) |-> ##2 (status_out[2] == $past(mem_fail_in, 2)))
		else $error("memory flag not loaded");
	chk_mem_hold: assert property (
		(!$past(rst_in, 3) && !$past(rst_in, 2) && !$past(rst_in)) |->
		$stable(status_out[2]))
		else $error("memory flag changed");
	chk_drive_scl_low: assert property (
		$rose(sda_oe_out) |-> !scl_in)
		else $error("sda pulled while scl high");
endmodule

bind pst_i2c_target pst_i2c_target_props u_pst_i2c_target_props (
	.ref_clk_in, .rst_in, .scl_in, .scl_oe_out, .sda_out, .sda_oe_out,
	.mem_fail_in, .meas_start_out, .operating_out, .status_out
);

// *** verification/tb_pst_i2c_target.sv ***
`timescale 1ns/1ps

module tb_pst_i2c_target;
	logic        ref_clk_in    = 1'b0;
	logic        rst_in        = 1'b1;
	logic [2:0]  addr_sel_in   = 3'h0;
	logic        mem_fail_in   = 1'b0;
	logic [23:0] meas_data_in  = 24'h000000;
	logic        meas_sat_in   = 1'b0;
	logic        meas_valid_in = 1'b0;
	logic        scl_out, scl_oe_out, sda_out, sda_oe_out;
	logic        meas_start_out, operating_out, meas_ready_out;
	logic [7:0]  status_out;
	logic        m_scl_oe, m_sda_oe;
	logic        watch         = 1'b0;
	logic        drove         = 1'b0;
	int          errors        = 0;
	int          n_checks      = 0;
	int          n_start       = 0;
	wire         scl_in = !(m_scl_oe || (scl_oe_out === 1'b1 && !scl_out));
	wire         sda_in = !(m_sda_oe || (sda_oe_out === 1'b1 && !sda_out));

	pst_i2c_target u_pst_i2c_target (
		.ref_clk_in, .rst_in, .scl_in, .scl_out, .scl_oe_out, .sda_in,
		.sda_out, .sda_oe_out, .addr_sel_in, .mem_fail_in, .meas_start_out,
		.operating_out, .meas_data_in, .meas_sat_in, .meas_valid_in,
		.meas_ready_out, .status_out
	);
	pst_i2c_master u_pst_i2c_master (
		.clk_in(ref_clk_in), .sda_in, .scl_oe_out(m_scl_oe),
		.sda_oe_out(m_sda_oe)
	);

	always #4 ref_clk_in = ~ref_clk_in;

	always @(posedge ref_clk_in) begin
		if (meas_start_out === 1'b1)
			n_start <= n_start + 1;
		if (watch && sda_oe_out === 1'b1)
			drove <= 1'b1;
	end

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	// Called at a clock edge; leaves valid high for the caller to drop
	task automatic push(input logic [23:0] d, input logic s, output logic ok);
		meas_data_in <= d;
		meas_sat_in <= s;
		meas_valid_in <= 1'b1;
		#1 ok = meas_ready_out;
		@(posedge ref_clk_in);
	endtask

	task automatic addr(input logic [6:0] ad, input logic rd, input logic e);
		logic [7:0] r;
		logic       a;
		u_pst_i2c_master.start();
		u_pst_i2c_master.xfer({ad, rd}, 1'b1, r, a);
		chk({7'h00, a}, {7'h00, e});
	endtask

	task automatic wr(input logic [23:0] d);
		logic [7:0] r;
		logic       a;
		addr(7'h18, 1'b0, 1'b0);
		for (int i = 2; i >= 0; i--) begin
			u_pst_i2c_master.xfer(d[8*i +: 8], 1'b1, r, a);
			chk({7'h00, a}, 8'h00);
		end
		u_pst_i2c_master.stop();
	endtask

	// Reads n bytes, not-acknowledging the last, then stops
	task automatic rd_bytes(input int n, input logic [39:0] e);
		logic [7:0] r;
		logic       a;
		for (int i = 0; i < n; i++) begin
			u_pst_i2c_master.xfer(8'hFF, i == n - 1, r, a);
			chk(r, e[39 - 8*i -: 8]);
		end
		u_pst_i2c_master.stop();
		chk({7'h00, sda_oe_out}, 8'h00);
		chk({7'h00, sda_in}, 8'h01);
	endtask

	task automatic t_power();
		chk(status_out, 8'h40);
		addr(7'h18, 1'b1, 1'b0);
		rd_bytes(5, 40'h40000000FF);
		$display("Test power done");
	endtask

	task automatic t_measure();
		logic ok;
		wr(24'hAA0000);
		cyc(4);
		chk(n_start[7:0], 8'h01);
		chk({7'h00, operating_out}, 8'h01);
		chk(status_out, 8'h60);
		addr(7'h18, 1'b1, 1'b0);
		rd_bytes(1, 40'h6000000000);
		wr(24'hAA0000);
		chk(n_start[7:0], 8'h01);
		@(posedge ref_clk_in);
		push(24'hABCDEF, 1'b1, ok);
		meas_valid_in <= 1'b0;
		for (int i = 0; i < 20 && status_out[5] !== 1'b0; i++)
			@(posedge ref_clk_in);
		chk(status_out, 8'h41);
		if (status_out[5] !== 1'b0) begin
			errors++;
			report_and_stop();
		end
		chk({7'h00, operating_out}, 8'h00);
		addr(7'h18, 1'b1, 1'b0);
		rd_bytes(4, 40'h41ABCDEF00);
		$display("Test measure done");
	endtask

	task automatic t_addr();
		logic [6:0] tbl [8] = '{7'h18, 7'h08, 7'h28, 7'h38,
			7'h48, 7'h58, 7'h68, 7'h78};
		for (int s = 0; s < 8; s++) begin
			@(posedge ref_clk_in);
			addr_sel_in <= s[2:0];
			cyc(5);
			watch = 1'b1;
			addr(tbl[s] ^ 7'h10, 1'b1, 1'b1);
			u_pst_i2c_master.stop();
			watch = 1'b0;
			chk({7'h00, drove}, 8'h00);
			addr(tbl[s], 1'b1, 1'b0);
			rd_bytes(1, 40'h4100000000);
		end
		@(posedge ref_clk_in);
		addr_sel_in <= 3'h0;
		cyc(5);
		$display("Test address done");
	endtask

	task automatic t_fill();
		logic ok;
		int   n;
		n = 0;
		ok = 1'b1;
		addr(7'h18, 1'b1, 1'b0);
		cyc(3);
		for (int i = 0; i < 40 && ok === 1'b1; i++) begin
			push(24'h5A0000 | i[23:0], 1'b0, ok);
			if (ok === 1'b1)
				n++;
		end
		meas_valid_in <= 1'b0;
		chk(n[7:0], 8'h20);
		chk({7'h00, meas_ready_out}, 8'h00);
		if (ok === 1'b1) begin
			errors++;
			report_and_stop();
		end
		rd_bytes(1, 40'h4100000000);
		cyc(80);
		addr(7'h18, 1'b1, 1'b0);
		rd_bytes(4, 40'h405A001F00);
		$display("Test fill done");
	endtask

	task automatic t_memfail();
		@(posedge ref_clk_in);
		mem_fail_in <= 1'b1;
		rst_in <= 1'b1;
		cyc(20);
		rst_in <= 1'b0;
		cyc(5);
		mem_fail_in <= 1'b0;
		chk(status_out, 8'h44);
		cyc(5);
		chk(status_out, 8'h44);
		$display("Test memory flag done");
	endtask

	initial begin
		cyc(20);
		rst_in <= 1'b0;
		cyc(5);
		t_power();
		t_measure();
		t_addr();
		t_fill();
		t_memfail();
		report_and_stop();
	end
endmodule
